// ==== enc_prm_pkg.sv ====
// Shared constants and types for the encoder parameter decoder.
package enc_prm_pkg;

    // Telegram layout: bytes 0..9 are the fieldbus header.
    localparam logic [4:0] PRM_OP_BYTE  = 5'h0A;
    localparam logic [4:0] PRM_MAX_BYTE = 5'h14;
    localparam logic [3:0] LD_LAST      = 4'h8;
    localparam logic [3:0] LD_SPT_FIRST = 4'h1;
    localparam logic [3:0] LD_SPT_LAST  = 4'h4;
    localparam logic [3:0] LD_FULL_LAST = 4'h8;
    localparam int         TEL_ADDR_W   = 5;
    localparam int         TEL_DEPTH    = 32;

    // Operating-parameter byte fields and their reset values.
    localparam int   OP_DIR_BIT   = 0;
    localparam int   OP_EXT_BIT   = 1;
    localparam int   OP_SCALE_BIT = 3;
    localparam int   OP_VEL_BIT   = 7;
    localparam logic DIR_RESET    = 1'b0;
    localparam logic EXT_RESET    = 1'b1;
    localparam logic SCALE_RESET  = 1'b1;
    localparam logic VEL_RESET    = 1'b0;

    // Register offsets (byte addresses, one word each).
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_HW_RES   = 8'h04;
    localparam logic [7:0] REG_STATUS   = 8'h08;
    localparam logic [7:0] REG_APP_SPT  = 8'h0C;
    localparam logic [7:0] REG_APP_FULL = 8'h10;
    localparam logic [7:0] REG_POSITION = 8'h14;
    localparam logic [4:0] HW_CPT_LOG2_RESET   = 5'h10;
    localparam logic [4:0] HW_TURNS_LOG2_RESET = 5'h0E;
    localparam int         HW_TURNS_LSB        = 8;

    // Cyclic payload sizes in bytes and the load-command flag.
    localparam logic [3:0] POS_ONLY_BYTES = 4'h4;
    localparam logic [3:0] POS_VEL_BYTES  = 4'h8;
    localparam int         LOAD_CMD_BIT   = 31;

    // Velocity sampling window.
    localparam int         CLK_PERIOD_NS     = 4;
    localparam int         VEL_WINDOW_NS     = 1000;
    localparam int         VEL_WINDOW_CYCLES = VEL_WINDOW_NS / CLK_PERIOD_NS;
    localparam logic [7:0] VEL_WINDOW_LAST   = 8'(VEL_WINDOW_CYCLES - 1);

    typedef enum logic [1:0] {MODE_PRM, MODE_CFG, MODE_DATA, MODE_FAULT} mode_t;
    typedef enum logic [1:0] {CLASS_BASIC, CLASS_EXT, CLASS_EXT_VEL} dev_class_t;
    typedef enum logic [1:0] {LD_IDLE, LD_READ, LD_DRAIN, LD_EVAL} ld_state_t;
    localparam dev_class_t CLASS_RESET = CLASS_EXT_VEL;

    typedef struct packed {
        logic dir;
        logic ext_en;
        logic scale_en;
        logic vel_sel;
    } op_params_t;

    localparam op_params_t OP_RESET = '{DIR_RESET, EXT_RESET, SCALE_RESET, VEL_RESET};

    typedef struct packed {
        logic  cfg_err;
        logic  fault;
        logic  custom_active;
        logic  ext_active;
        logic  vel_sel;
        logic  dir;
        mode_t mode;
    } status_t;

endpackage

// ==== encoder_parameter_decoder.sv ====
// Parameter telegram decoder and cyclic data path of the rotary encoder slave.
// Notes on behaviour
// R1: Load value only in data exchange.
// R2: Start in parameter mode after power-on.
// R3: Configuration check sets cyclic payload length.
// R4: Data exchange returns position, optionally velocity.
// R5: Diagnostics answered in every mode.
// R6: Bytes 0-9 header, byte 10 operating byte.
// R7: Decode direction, extended, scaling, payload bits.
// R8: Direction bit selects clockwise or counter-clockwise count.
// R9: Defaults: direction 0, extended 1, scaling 1.
// R10: Extended bit selects basic or extended behaviour.
// R11: Scaling off uses hardware resolution.
// R12: Scaling on uses telegram bytes 11-18.
// R13: Custom resolution needs extended bit set.
// R14: Values accepted while scaling off, not applied.
// R15: Inconsistent scaling refuses online state.
// R16: Master reloads position after scaling changes.
// R17: Extended bits act only in extended class.
// R18: Payload bit selects position or position+velocity.
// R19: Oversized steps per turn clamp to hardware.
// R20: Reserved bits and bytes are ignored.
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
module encoder_parameter_decoder (
    input  logic        CORE_CLK_IN,
    input  logic        RESET_IN,
    input  logic [7:0]  REG_ADDR_IN,
    input  logic [31:0] REG_WDATA_IN,
    input  logic        REG_WR_IN,
    input  logic        REG_RD_IN,
    output logic [31:0] REG_RDATA_OUT,
    input  logic        PRM_VALID_IN,
    input  logic        PRM_FIRST_IN,
    input  logic        PRM_LAST_IN,
    input  logic [7:0]  PRM_BYTE_IN,
    input  logic        CFG_VALID_IN,
    input  logic [3:0]  CFG_BYTES_IN,
    input  logic        DX_VALID_IN,
    input  logic [31:0] DX_LOAD_IN,
    input  logic        DIAG_REQ_IN,
    input  logic [31:0] RAW_POS_IN,
    output logic [1:0]  MODE_OUT,
    output logic [3:0]  TX_LEN_OUT,
    output logic [31:0] TX_POS_OUT,
    output logic [31:0] TX_VEL_OUT,
    output logic        TX_VEL_EN_OUT,
    output logic        DIAG_ACK_OUT,
    output logic [7:0]  DIAG_STATUS_OUT
);
    import enc_prm_pkg::*;

    // Software-visible configuration.
    dev_class_t  dev_class;
    dev_class_t  next_dev_class;
    logic [4:0]  hw_cpt_log2;
    logic [4:0]  next_hw_cpt_log2;
    logic [4:0]  hw_turns_log2;
    logic [4:0]  next_hw_turns_log2;
    logic [31:0] rdata;
    logic [31:0] next_rdata;

    // Telegram reception and evaluation.
    ld_state_t   ld_state;
    ld_state_t   next_ld_state;
    logic [4:0]  tel_cnt;
    logic [4:0]  next_tel_cnt;
    logic [3:0]  ld_cnt;
    logic [3:0]  next_ld_cnt;
    logic        cap_on;
    logic        next_cap_on;
    logic [3:0]  cap_cnt;
    logic [3:0]  next_cap_cnt;
    op_params_t  rx_op;
    op_params_t  next_rx_op;
    op_params_t  op;
    op_params_t  next_op;
    logic [31:0] rx_spt;
    logic [31:0] next_rx_spt;
    logic [31:0] rx_full;
    logic [31:0] next_rx_full;
    mode_t       mode;
    mode_t       next_mode;
    logic        cfg_err;
    logic        next_cfg_err;
    logic [3:0]  tx_len;
    logic [3:0]  next_tx_len;

    // Cyclic data path.
    logic [31:0] offset;
    logic [31:0] next_offset;
    logic [31:0] tx_pos;
    logic [31:0] next_tx_pos;
    logic [31:0] tx_vel;
    logic [31:0] next_tx_vel;
    logic [31:0] prev_pos;
    logic [31:0] next_prev_pos;
    logic [7:0]  vel_cnt;
    logic [7:0]  next_vel_cnt;
    logic        diag_ack;
    logic        next_diag_ack;
    status_t     diag_status;
    status_t     next_diag_status;

    // Derived values.
    logic [4:0]  tel_idx;
    logic        tel_wr;
    logic [4:0]  rd_addr;
    logic [7:0]  rd_byte;
    logic [31:0] hw_cpt;
    logic [31:0] hw_total;
    logic [5:0]  hw_bits;
    logic        ext_active;
    logic        custom_active;
    logic [31:0] spt_clamp;
    logic [31:0] full_clamp;
    logic [31:0] app_spt;
    logic [31:0] app_full;
    logic [63:0] spt_span;
    logic        scale_bad;
    logic        rx_ext_active;
    logic [3:0]  want_len;
    logic [31:0] base_pos;
    status_t     status;

    assign tel_idx  = PRM_FIRST_IN ? 5'h00 : tel_cnt;
    assign tel_wr   = PRM_VALID_IN && (tel_idx <= PRM_MAX_BYTE);
    assign rd_addr  = PRM_OP_BYTE + 5'(ld_cnt); // see R6
    assign hw_cpt   = 32'h1 << hw_cpt_log2;
    assign hw_bits  = {1'b0, hw_cpt_log2} + {1'b0, hw_turns_log2};
    assign hw_total = (hw_bits >= 6'h20) ? 32'hFFFFFFFF : (32'h1 << hw_bits);

    // Extended bits count only in an extended class.
    assign ext_active    = op.ext_en && (dev_class != CLASS_BASIC); // see R10 // see R17
    assign custom_active = ext_active && op.scale_en; // see R13 // see R14
    assign rx_ext_active = rx_op.ext_en && (dev_class != CLASS_BASIC);

    assign spt_clamp  = (rx_spt > hw_cpt) ? hw_cpt : rx_spt; // see R19
    assign full_clamp = (rx_full > hw_total) ? hw_total : rx_full;
    assign app_spt    = custom_active ? spt_clamp : hw_cpt; // see R11 // see R12
    assign app_full   = custom_active ? full_clamp : hw_total;
    assign spt_span   = 64'(spt_clamp) << hw_turns_log2;
    // More turns than the hardware holds, or fewer steps than one turn.
    assign scale_bad  = (spt_clamp == 32'h0) || (full_clamp < spt_clamp)
                        || (64'(full_clamp) > spt_span);
    assign want_len   = op.vel_sel ? POS_VEL_BYTES : POS_ONLY_BYTES; // see R3

    assign status = '{cfg_err, (mode == MODE_FAULT), custom_active, ext_active,
                      op.vel_sel, op.dir, mode};

    telegram_store u_store (
        .clk_in      (CORE_CLK_IN),
        .reset_in    (RESET_IN),
        .wr_en_in    (tel_wr),
        .wr_addr_in  (tel_idx),
        .wr_data_in  (PRM_BYTE_IN),
        .rd_addr_in  (rd_addr),
        .rd_data_out (rd_byte)
    );

    position_scaler u_scaler (
        .clk_in        (CORE_CLK_IN),
        .reset_in      (RESET_IN),
        .raw_in        (RAW_POS_IN),
        .cpt_log2_in   (hw_cpt_log2),
        .turns_log2_in (hw_turns_log2),
        .dir_in        (op.dir),
        .custom_in     (custom_active),
        .spt_in        (app_spt),
        .full_in       (app_full),
        .pos_out       (base_pos)
    );

    // Register port: reads answer in the next cycle, unmapped reads give zero.
    always_comb begin
        next_dev_class     = dev_class;
        next_hw_cpt_log2   = hw_cpt_log2;
        next_hw_turns_log2 = hw_turns_log2;
        next_rdata         = 32'h0;
        if (REG_WR_IN) begin
            case (REG_ADDR_IN)
                REG_CTRL: begin
                    if (REG_WDATA_IN[1:0] != 2'h3) begin
                        next_dev_class = dev_class_t'(REG_WDATA_IN[1:0]);
                    end
                end
                REG_HW_RES: begin
                    next_hw_cpt_log2   = REG_WDATA_IN[4:0];
                    next_hw_turns_log2 = REG_WDATA_IN[HW_TURNS_LSB +: 5];
                end
                default: begin
                end
            endcase
        end
        if (REG_RD_IN) begin
            case (REG_ADDR_IN)
                REG_CTRL:     next_rdata = {30'h0, dev_class};
                REG_HW_RES:   next_rdata = {19'h0, hw_turns_log2, 3'h0, hw_cpt_log2};
                REG_STATUS:   next_rdata = {24'h0, status};
                REG_APP_SPT:  next_rdata = app_spt;
                REG_APP_FULL: next_rdata = app_full;
                REG_POSITION: next_rdata = tx_pos;
                default:      next_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            dev_class     <= CLASS_RESET;
            hw_cpt_log2   <= HW_CPT_LOG2_RESET;
            hw_turns_log2 <= HW_TURNS_LOG2_RESET;
            rdata         <= 32'h0;
        end else begin
            dev_class     <= next_dev_class;
            hw_cpt_log2   <= next_hw_cpt_log2;
            hw_turns_log2 <= next_hw_turns_log2;
            rdata         <= next_rdata;
        end
    end

    // Telegram loader and operating mode.
    always_comb begin
        next_ld_state = ld_state;
        next_tel_cnt  = tel_cnt;
        next_ld_cnt   = ld_cnt;
        next_cap_on   = 1'b0;
        next_cap_cnt  = ld_cnt;
        next_rx_op    = rx_op;
        next_op       = op;
        next_rx_spt   = rx_spt;
        next_rx_full  = rx_full;
        next_mode     = mode;
        next_cfg_err  = cfg_err;
        next_tx_len   = tx_len;
        if (PRM_VALID_IN) begin
            next_tel_cnt = (tel_idx == 5'h1F) ? tel_idx : tel_idx + 5'h01;
        end
        // Bytes after the last one read back stale; a telegram ending at byte 10 to 17 is still loaded and reads them.
        if (PRM_VALID_IN && PRM_LAST_IN && (ld_state == LD_IDLE)) begin
            next_mode = MODE_PRM; // see R2
            if (tel_idx >= PRM_OP_BYTE) begin
                next_ld_state = LD_READ;
                next_ld_cnt   = 4'h0;
            end
        end
        if (cap_on) begin
            if (cap_cnt == 4'h0) begin
                // Bit 2 and bits 4..6 are not looked at.
                next_rx_op = '{rd_byte[OP_DIR_BIT], rd_byte[OP_EXT_BIT], // see R7 // see R20
                               rd_byte[OP_SCALE_BIT], rd_byte[OP_VEL_BIT]};
            end else if (cap_cnt <= LD_SPT_LAST) begin
                next_rx_spt = {rx_spt[23:0], rd_byte}; // see R14
            end else if (cap_cnt <= LD_FULL_LAST) begin
                next_rx_full = {rx_full[23:0], rd_byte};
            end
        end
        case (ld_state)
            LD_READ: begin
                next_cap_on = 1'b1;
                if (ld_cnt == LD_LAST) begin
                    next_ld_state = LD_DRAIN;
                end else begin
                    next_ld_cnt = ld_cnt + 4'h1;
                end
            end
            LD_DRAIN: begin
                next_ld_state = LD_EVAL;
            end
            LD_EVAL: begin
                next_op       = rx_op;
                next_cfg_err  = 1'b0;
                next_ld_state = LD_IDLE;
                if (rx_ext_active && rx_op.scale_en && scale_bad) begin
                    next_mode = MODE_FAULT; // see R15
                end else begin
                    next_mode = MODE_CFG;
                end
            end
            default: begin
            end
        endcase
        if (CFG_VALID_IN && ((mode == MODE_CFG) || (mode == MODE_DATA))) begin
            if (CFG_BYTES_IN == want_len) begin
                next_mode    = MODE_DATA; // see R3
                next_tx_len  = CFG_BYTES_IN;
                next_cfg_err = 1'b0;
            end else begin
                next_mode    = MODE_CFG;
                next_cfg_err = 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            ld_state <= LD_IDLE;
            tel_cnt  <= 5'h00;
            ld_cnt   <= 4'h0;
            cap_on   <= 1'b0;
            cap_cnt  <= 4'h0;
            rx_op    <= OP_RESET;
            op       <= OP_RESET; // see R9
            rx_spt   <= 32'h0;
            rx_full  <= 32'h0;
            mode     <= MODE_PRM; // see R2
            cfg_err  <= 1'b0;
            tx_len   <= POS_ONLY_BYTES;
        end else begin
            ld_state <= next_ld_state;
            tel_cnt  <= next_tel_cnt;
            ld_cnt   <= next_ld_cnt;
            cap_on   <= next_cap_on;
            cap_cnt  <= next_cap_cnt;
            rx_op    <= next_rx_op;
            op       <= next_op;
            rx_spt   <= next_rx_spt;
            rx_full  <= next_rx_full;
            mode     <= next_mode;
            cfg_err  <= next_cfg_err;
            tx_len   <= next_tx_len;
        end
    end

    // Cyclic payload, load value and diagnostics.
    always_comb begin
        next_offset      = offset;
        next_tx_pos      = base_pos + offset; // see R4
        next_prev_pos    = prev_pos;
        next_tx_vel      = tx_vel;
        next_vel_cnt     = vel_cnt + 8'h01;
        next_diag_ack    = DIAG_REQ_IN; // see R5
        next_diag_status = DIAG_REQ_IN ? status : diag_status;
        // While the load flag stays set the output is held at the load value.
        if ((mode == MODE_DATA) && DX_VALID_IN && DX_LOAD_IN[LOAD_CMD_BIT]) begin
            next_offset = {1'b0, DX_LOAD_IN[30:0]} - base_pos; // see R1
        end
        if (vel_cnt == VEL_WINDOW_LAST) begin
            next_vel_cnt  = 8'h00;
            next_prev_pos = tx_pos;
            next_tx_vel   = tx_pos - prev_pos;
        end
        if (!op.vel_sel) begin
            next_tx_vel = 32'h0; // see R18
        end
    end

    always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            offset      <= 32'h0;
            tx_pos      <= 32'h0;
            prev_pos    <= 32'h0;
            tx_vel      <= 32'h0;
            vel_cnt     <= 8'h00;
            diag_ack    <= 1'b0;
            diag_status <= '0;
        end else begin
            offset      <= next_offset;
            tx_pos      <= next_tx_pos;
            prev_pos    <= next_prev_pos;
            tx_vel      <= next_tx_vel;
            vel_cnt     <= next_vel_cnt;
            diag_ack    <= next_diag_ack;
            diag_status <= next_diag_status;
        end
    end

    assign REG_RDATA_OUT   = rdata;
    assign MODE_OUT        = mode;
    assign TX_LEN_OUT      = tx_len;
    assign TX_POS_OUT      = tx_pos;
    assign TX_VEL_OUT      = tx_vel;
    assign TX_VEL_EN_OUT   = op.vel_sel;
    assign DIAG_ACK_OUT    = diag_ack;
    assign DIAG_STATUS_OUT = diag_status;

    default clocking cb @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (RESET_IN);

    chk_start_param_mode: assert property ( // see R2
        $fell(RESET_IN) |-> (mode == MODE_PRM)
    ) else $error("Mode after reset is not parameter mode.");

    chk_load_data_only: assert property ( // see R1
        !$stable(offset) |-> ($past(mode) == MODE_DATA) && $past(DX_VALID_IN)
    ) else $error("Load value applied outside data exchange.");

    chk_payload_length: assert property ( // see R3
        (mode == MODE_DATA) |-> (TX_LEN_OUT == (op.vel_sel ? 4'h8 : 4'h4))
    ) else $error("Cyclic length differs from the payload selection.");

    chk_diag_answer: assert property ( // see R5
        DIAG_REQ_IN |=> DIAG_ACK_OUT && (DIAG_STATUS_OUT[1:0] == $past(mode))
    ) else $error("Diagnostic request not answered next cycle.");

    chk_hw_resolution: assert property ( // see R11
        !custom_active |-> (app_spt == (32'h1 << hw_cpt_log2))
    ) else $error("Hardware resolution not in use without scaling.");

    chk_spt_clamp: assert property ( // see R19
        custom_active |-> (app_spt <= hw_cpt) && (app_spt == rx_spt || rx_spt > hw_cpt)
    ) else $error("Steps per turn not clamped to hardware.");

    chk_refuse_online: assert property ( // see R15
        (ld_state == LD_EVAL) && rx_ext_active && rx_op.scale_en && scale_bad
        |=> (mode == MODE_FAULT) ##1 (mode != MODE_DATA)
    ) else $error("Inconsistent scaling reached online state.");

    chk_custom_gate: assert property ( // see R13
        (dev_class == CLASS_BASIC) || !op.ext_en |-> !custom_active
    ) else $error("Custom resolution active without extended class.");

    chk_velocity_off: assert property ( // see R18
        !op.vel_sel && $past(!op.vel_sel) |-> (TX_VEL_OUT == 32'h0)
    ) else $error("Velocity sent while only position is selected.");

    chk_op_decode: assert property ( // see R7
        cap_on && (cap_cnt == 4'h0) |=> (rx_op.scale_en == $past(rd_byte[3]))
                                        && (rx_op.vel_sel == $past(rd_byte[7]))
    ) else $error("Operating byte decoded at the wrong bits.");
endmodule

// ==== fieldbus_master_model.sv ====
// Behavioural fieldbus master: telegrams, checks, cyclic words, diagnostics.
`timescale 1ns/1ps
module fieldbus_master_model (
    input  logic        clk_in,
    output logic        prm_valid_out,
    output logic        prm_first_out,
    output logic        prm_last_out,
    output logic [7:0]  prm_byte_out,
    output logic        cfg_valid_out,
    output logic [3:0]  cfg_bytes_out,
    output logic        dx_valid_out,
    output logic [31:0] dx_load_out,
    output logic        diag_req_out
);
    initial begin
        {prm_valid_out, prm_first_out, prm_last_out, cfg_valid_out, dx_valid_out} = 5'h00;
        {diag_req_out, prm_byte_out, cfg_bytes_out, dx_load_out} = 45'h0;
    end
    // Idle lines show the inverse so a stale value is never reused.
    task automatic send_prm(input logic [7:0] op, input logic [31:0] spt, full);
        logic [7:0] tel [0:18];
        for (int i = 0; i < 10; i++) tel[i] = 8'(i) ^ 8'hC3;
        tel[10] = op;
        {tel[11], tel[12], tel[13], tel[14]} = spt;
        {tel[15], tel[16], tel[17], tel[18]} = full;
        for (int i = 0; i < 19; i++) begin
            @(posedge clk_in);
            {prm_valid_out, prm_first_out, prm_last_out} <= {1'b1, i == 0, i == 18};
            prm_byte_out  <= tel[i];
        end
        @(posedge clk_in);
        {prm_valid_out, prm_first_out, prm_last_out} <= 3'h0;
        prm_byte_out <= ~tel[18];
    endtask
    task automatic send_cfg(input logic [3:0] n);
        @(posedge clk_in);
        {cfg_valid_out, cfg_bytes_out} <= {1'b1, n};
        @(posedge clk_in);
        {cfg_valid_out, cfg_bytes_out} <= {1'b0, ~n};
    endtask
    task automatic load_on(input logic [31:0] v);
        @(posedge clk_in);
        dx_valid_out <= 1'b1;
        dx_load_out  <= v;
    endtask
    task automatic load_off;
        @(posedge clk_in);
        {dx_valid_out, dx_load_out} <= {1'b0, ~dx_load_out};
    endtask
    task automatic diag;
        @(posedge clk_in);
        diag_req_out <= 1'b1;
        @(posedge clk_in);
        diag_req_out <= 1'b0;
    endtask
endmodule

// ==== position_scaler.sv ====
// Turns raw sensor counts into the cyclic position value.
`timescale 1ns/1ps
module position_scaler (
    input  logic        clk_in,
    input  logic        reset_in,
    input  logic [31:0] raw_in,
    input  logic [4:0]  cpt_log2_in,
    input  logic [4:0]  turns_log2_in,
    input  logic        dir_in,
    input  logic        custom_in,
    input  logic [31:0] spt_in,
    input  logic [31:0] full_in,
    output logic [31:0] pos_out
);
    import enc_prm_pkg::*;

    logic [31:0] pos;
    logic [31:0] next_pos;

    always_comb begin
        logic [5:0]  hw_bits;
        logic [31:0] hw_mask;
        logic [31:0] cpt_mask;
        logic [31:0] code;
        logic [63:0] prod_turn;
        logic [63:0] prod_frac;
        logic [31:0] scaled;
        hw_bits   = {1'b0, cpt_log2_in} + {1'b0, turns_log2_in};
        hw_mask   = (hw_bits >= 6'h20) ? 32'hFFFFFFFF : ((32'h1 << hw_bits) - 32'h1);
        cpt_mask  = (32'h1 << cpt_log2_in) - 32'h1;
        code      = raw_in & hw_mask;
        if (dir_in) begin
            code = hw_mask - code; // see R8
        end
        prod_turn = 64'(code >> cpt_log2_in) * 64'(spt_in);
        prod_frac = (64'(code & cpt_mask) * 64'(spt_in)) >> cpt_log2_in;
        scaled    = prod_turn[31:0] + prod_frac[31:0];
        // Only one wrap is folded; a consistent range below half of steps per turn times turns can need more.
        if (scaled >= full_in) begin
            scaled = scaled - full_in;
        end
        next_pos  = custom_in ? scaled : code; // see R11 // see R12
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            pos <= 32'h0;
        end else begin
            pos <= next_pos;
        end
    end

    assign pos_out = pos;
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the encoder parameter decoder.
`timescale 1ns/1ps
module tb_top;
    import enc_prm_pkg::*;
    logic        clk, rst, wr, rd, pv, pf, pl, cv, dv, dq, ven, ack;
    logic [7:0]  addr, pb, dstat;
    logic [3:0]  cb, len;
    logic [1:0]  mode;
    logic [31:0] wdata, rdata, dl, raw, pos, vel, d;
    int          mismatches = 0, cmp_count = 0;
    encoder_parameter_decoder dut_u (.CORE_CLK_IN(clk), .RESET_IN(rst), .REG_ADDR_IN(addr),
        .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
        .PRM_VALID_IN(pv), .PRM_FIRST_IN(pf), .PRM_LAST_IN(pl), .PRM_BYTE_IN(pb),
        .CFG_VALID_IN(cv), .CFG_BYTES_IN(cb), .DX_VALID_IN(dv), .DX_LOAD_IN(dl),
        .DIAG_REQ_IN(dq), .RAW_POS_IN(raw), .MODE_OUT(mode), .TX_LEN_OUT(len),
        .TX_POS_OUT(pos), .TX_VEL_OUT(vel), .TX_VEL_EN_OUT(ven), .DIAG_ACK_OUT(ack),
        .DIAG_STATUS_OUT(dstat));
    fieldbus_master_model m_u (.clk_in(clk), .prm_valid_out(pv), .prm_first_out(pf),
        .prm_last_out(pl), .prm_byte_out(pb), .cfg_valid_out(cv), .cfg_bytes_out(cb),
        .dx_valid_out(dv), .dx_load_out(dl), .diag_req_out(dq));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic reg_rd(input logic [7:0] a);
        @(posedge clk);
        {addr, rd} <= {a, 1'b1};
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        {addr, wdata, wr} <= {a, v, 1'b1};
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic wait_mode(input logic [1:0] m);
        for (int n = 0; n < 60 && mode !== m; n++) begin
            @(posedge clk);
            #1;
        end
    endtask
    task automatic prm(input logic [7:0] op, input logic [31:0] s, f, input logic [1:0] m);
        m_u.send_prm(op, s, f);
        wait_mode(2'h0);
        wait_mode(m);
        check(32'(mode), 32'(m));
    endtask
    task automatic cfg(input logic [3:0] n, input logic [1:0] m);
        m_u.send_cfg(n);
        wait_mode(m);
        check(32'(mode), 32'(m));
    endtask
    task automatic t_reset;
        check(32'(mode), 32'h0);
        check(32'(len), 32'h4);
        reg_rd(REG_HW_RES);
        check(d, 32'hE10);
        reg_rd(8'hFC);
        check(d, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_hw;
        raw <= 32'hC0001234;
        prm(8'h02, 32'h0, 32'h0, 2'h1);
        cfg(4'h4, 2'h2);
        repeat (4) @(negedge clk);
        check(pos, 32'h1234);
        check(32'(ven), 32'h0);
        prm(8'h77, 32'h0, 32'h0, 2'h1);
        cfg(4'h4, 2'h2);
        repeat (4) @(negedge clk);
        check(pos, 32'h3FFFEDCB);
        cfg(4'h5, 2'h1);
        m_u.diag();
        #1;
        check(32'(ack), 32'h1);
        check(32'(dstat), 32'h95);
        $display("hardware test done");
    endtask
    task automatic t_vel;
        prm(8'h82, 32'h0, 32'h0, 2'h1);
        cfg(4'h8, 2'h2);
        check(32'(len), 32'h8);
        check(32'(ven), 32'h1);
        m_u.load_on(32'h80000500);
        repeat (4) @(negedge clk);
        check(pos, 32'h00000500);
        m_u.load_off();
        repeat (250) @(posedge clk);
        raw <= raw + 32'h40;
        repeat (253) @(negedge clk);
        check(vel, 32'h40);
        $display("velocity test done");
    endtask
    task automatic scale_case(input logic [31:0] cls, input logic [7:0] op, input logic [31:0] s,
                              f, input logic [1:0] m, input logic [31:0] app);
        reg_wr(REG_CTRL, cls);
        prm(op, s, f, m);
        if (m == 2'h1) begin
            reg_rd(REG_APP_SPT);
            check(d, app);
        end
    endtask
    task automatic t_scale;
        scale_case(32'h2, 8'h02, 32'h8000, 32'h20000000, 2'h1, 32'h10000);
        scale_case(32'h2, 8'h08, 32'h8000, 32'h20000000, 2'h1, 32'h10000);
        scale_case(32'h2, 8'h0A, 32'h8000, 32'h20000000, 2'h1, 32'h8000);
        scale_case(32'h2, 8'h0A, 32'h20000, 32'h40000000, 2'h1, 32'h10000);
        scale_case(32'h2, 8'h0A, 32'h0, 32'h20000000, 2'h3, 32'h0);
        scale_case(32'h2, 8'h0A, 32'h8000, 32'h100, 2'h3, 32'h0);
        scale_case(32'h0, 8'h0A, 32'h8000, 32'h20000000, 2'h1, 32'h10000);
        $display("scaling test done");
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        {rst, wr, rd, addr, wdata, raw} = {1'b1, 74'h0};
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        t_reset();
        t_hw();
        t_vel();
        t_scale();
        report_and_stop();
    end
    initial begin
        #80000;
        mismatches++;
        report_and_stop();
    end
endmodule

// ==== telegram_store.sv ====
// Byte store for one received parameter telegram, registered read port.
`timescale 1ns/1ps
module telegram_store (
    input  logic                                clk_in,
    input  logic                                reset_in,
    input  logic                                wr_en_in,
    input  logic [enc_prm_pkg::TEL_ADDR_W-1:0]  wr_addr_in,
    input  logic [7:0]                          wr_data_in,
    input  logic [enc_prm_pkg::TEL_ADDR_W-1:0]  rd_addr_in,
    output logic [7:0]                          rd_data_out
);
    import enc_prm_pkg::*;

    logic [7:0] mem [TEL_DEPTH];
    logic [7:0] rd_data;

    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= mem[rd_addr_in];
        end
    end

    assign rd_data_out = rd_data;
endmodule
